// >>> common/fail_log_pkg.sv
// constants, field layouts and carriers for the fail latch and lifetime log
// assumes one 200 MHz clock and a 32-bit apb register port
package fail_log_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int TICK_MS = 1000;
  localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
  localparam int PERSIST_S = 60;
  localparam int AVG_STEP = 10;
  localparam logic [31:0] SAMPLE_LIMIT = 32'd140000000;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_LT_BASE = 8'h20;
  localparam logic [7:0] OFS_LT_AVG = 8'h48;
  localparam logic [7:0] OFS_LT_SAMPLES = 8'h4c;

  // ****************************************************************
  // field layouts and reset values
  // ****************************************************************
  localparam logic [15:0] ENABLE_WMASK = 16'h0fff;
  localparam logic [15:0] SHUTDOWN_MASK = 16'h7fff;
  localparam int FUSE_BIT = 15;
  localparam int IRQ_W = 3;
  localparam int IRQ_NEW_FLAG = 0;
  localparam int IRQ_SHUTDOWN = 1;
  localparam int IRQ_STORE = 2;

  // tracked extremes: 0 max temp, 1 min temp, 2 max cell, 3 min cell,
  // 4 max pack, 5 min pack, 6 max chg cur, 7 max dsg cur,
  // 8 max chg pwr, 9 max dsg pwr
  localparam int LT_N = 10;
  localparam logic [LT_N-1:0] LT_IS_MIN = 10'b00_0010_1010;
  localparam logic [15:0] LT_STEP [LT_N] = '{16'd10, 16'd10, 16'd25,
    16'd25, 16'd100, 16'd100, 16'd100, 16'd100, 16'd1000, 16'd1000};
  localparam logic [15:0] LT_RESET [LT_N] = '{16'h0000, 16'd1400,
    16'h0000, 16'd10000, 16'h0000, 16'd20000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000};

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic fuse_blow_failure;
    logic unused6;
    logic unused5;
    logic open_thermistor_fail;
    logic discharge_overcurrent_fail;
    logic charge_overcurrent_fail;
    logic frontend_periodic_link_fail;
    logic frontend_link_fail;
    logic storage_fault_fail;
    logic discharge_switch_fail;
    logic charge_switch_fail;
    logic cell_imbalance_fail;
    logic discharge_overtemp_fail;
    logic charge_overtemp_fail;
    logic safety_overvolt_fail;
    logic ext_input_fail;
  } fail_flags_s;

  typedef struct packed {
    logic signed [15:0] temp;
    logic temp_ok;
    logic [15:0] cell_hi;
    logic [15:0] cell_lo;
    logic [15:0] pack;
    logic signed [15:0] avg_cur;
    logic signed [15:0] avg_pwr;
  } meas_s;

  typedef struct packed {
    logic [LT_N-1:0][15:0] ext;
    logic signed [15:0] avg_temp;
    logic [31:0] samples;
  } lifetime_s;

endpackage : fail_log_pkg

// >>> verification/fail_log_sva.sv
// assertions on the fail latch, register port and store handshake
// assumes it is bound onto every fail_log instance
`timescale 1ns/1ps
module fail_log_sva
  import fail_log_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // causes, gauging, store, shutdown
  input wire logic [15:0] fail_cause,
  input wire logic gauging_enabled_flag,
  input wire logic nv_store_req,
  input wire lifetime_s nv_store_data,
  input wire logic nv_store_ack,
  input wire logic shutdown_n,
  input wire logic shutdown
);
  logic [15:0] en;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mirror of the action enable word, one edge late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en <= 16'h0000;
    end else if (psel && penable && pready && pwrite && paddr == 8'h04) begin
      en <= pwdata[15:0] & 16'h0fff;
    end
  end
  shut_compl_a: assert property (shutdown == !shutdown_n)
    else $error("shutdown pair differs");
  shut_hold_a: assert property (!shutdown_n |=> !shutdown_n)
    else $error("shutdown released");
  cause_shut_a: assert property (|(fail_cause & en) |=> !shutdown_n)
    else $error("enabled cause missed");
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("answer too long");
  err_ready_a: assert property (pslverr |-> pready && psel)
    else $error("stray error");
  nv_hold_a: assert property (nv_store_req && !nv_store_ack |=>
    nv_store_req && $stable(nv_store_data))
    else $error("store request dropped");
  nv_gate_a: assert property ($rose(nv_store_req) |->
    $past(gauging_enabled_flag))
    else $error("store while not gauging");
  cover property ($fell(shutdown_n));
  cover property (nv_store_req && nv_store_ack);
  cover property (pready && pslverr);
endmodule : fail_log_sva

bind fail_log fail_log_sva #(.TICK_LEN(TICK_LEN)) u_sva (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .fail_cause,
  .gauging_enabled_flag, .nv_store_req, .nv_store_data, .nv_store_ack,
  .shutdown_n, .shutdown);

// >>> verification/fail_log_test.sv
// self-checking bench for the fail latch and lifetime log
// assumes the store model answers store requests
`timescale 1ns/1ps
module fail_log_test
  import fail_log_pkg::*;
;
  localparam int TL = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] fail_cause;
  logic fuse_current_pin, meas_valid, gauging_enabled_flag, slow;
  meas_s meas;
  lifetime_s nv_store_data, stored;
  logic nv_store_req, nv_store_ack, shutdown_n, shutdown, irq;
  int fail_count = 0;
  int n_checks = 0;
  logic [31:0] dflt [10] = '{0, 1400, 0, 10000, 0, 20000, 0, 0, 0, 0};
  logic [31:0] lt [10] = '{500, 500, 4000, 3000, 12000, 12000, 2000, 0, 0,
    5000};

  fail_log #(.TICK_LEN(TL)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fail_cause,
    .fuse_current_pin, .meas, .meas_valid, .gauging_enabled_flag,
    .nv_store_req, .nv_store_data, .nv_store_ack, .shutdown_n, .shutdown,
    .irq);
  nv_store_model u_nv (.pclk, .presetn, .nv_store_req, .nv_store_data,
    .nv_store_ack, .slow, .stored);

  always #2.5 pclk = ~pclk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic test_done;
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chb

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic pulse(input logic [15:0] c);
    fail_cause <= c;
    @(posedge pclk);
    fail_cause <= 16'h0000;
    cyc(2);
  endtask : pulse

  task automatic sm(input logic [15:0] t, input logic [15:0] c,
      input logic [15:0] p);
    meas.temp <= t;
    meas.avg_cur <= c;
    meas.avg_pwr <= p;
    meas_valid <= 1'b1;
    @(posedge pclk);
    meas_valid <= 1'b0;
    @(posedge pclk);
  endtask : sm

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults;
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 10; i++) begin
      rd(8'h20 + 8'(4 * i), dflt[i]);
    end
    rd(8'h48, 32'h0);
    rd(8'h4c, 32'h0);
    wr(8'h00, 32'hffff);
    rd(8'h00, 32'h0);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk(r, 32'h0);
    chb(e, 1'b1);
  endtask : t_defaults

  task automatic t_flags;
    wr(8'h04, 32'h0);
    pulse(16'h7fff);
    chb(shutdown_n, 1'b1);
    rd(8'h00, 32'h1fff);
    chb(irq, 1'b0);
    wr(8'h0c, 32'h1);
    cyc(2);
    chb(irq, 1'b1);
    rd(8'h08, 32'h1);
    cyc(2);
    chb(irq, 1'b0);
    rd(8'h08, 32'h0);
    wr(8'h04, 32'hffff);
    rd(8'h04, 32'h0fff);
    cyc(2);
    chb(shutdown, 1'b1);
    rd(8'h10, 32'h1);
    wr(8'h04, 32'h0);
    fuse_current_pin <= 1'b1;
    cyc(4 * TL);
    chb(shutdown_n, 1'b0);
    rd(8'h00, 32'h9fff);
  endtask : t_flags

  task automatic t_latch;
    fuse_current_pin <= 1'b0;
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
    chb(shutdown_n, 1'b1);
    wr(8'h04, 32'h8800);
    pulse(16'h0400);
    chb(shutdown_n, 1'b1);
    pulse(16'h8000);
    chb(shutdown_n, 1'b1);
    rd(8'h00, 32'h8400);
    pulse(16'h0800);
    chb(shutdown_n, 1'b0);
  endtask : t_latch

  task automatic t_life;
    sm(16'd500, 16'd2000, -16'sd5000);
    cyc(8);
    chb(nv_store_req, 1'b0);
    rd(8'h20, 32'h0);
    gauging_enabled_flag <= 1'b1;
    sm(16'd500, 16'd2000, -16'sd5000);
    cyc(20);
    for (int i = 0; i < 10; i++) begin
      rd(8'h20 + 8'(4 * i), lt[i]);
      chk(32'(stored.ext[i]), lt[i]);
    end
    rd(8'h48, 32'd500);
    rd(8'h4c, 32'd1);
    rd(8'h08, 32'h7);
  endtask : t_life

  task automatic t_persist;
    slow <= 1'b1;
    sm(16'd505, -16'sd3000, 16'd8000);
    cyc(20);
    rd(8'h3c, 32'd3000);
    rd(8'h40, 32'd8000);
    cyc(40 * TL);
    sm(16'd500, -16'sd3000, 16'd8000);
    sm(16'd505, -16'sd3000, 16'd8000);
    cyc(40 * TL);
    rd(8'h20, 32'd500);
    cyc(25 * TL);
    rd(8'h20, 32'd505);
  endtask : t_persist

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, meas_valid} = 4'h0;
    {paddr, pwdata, fail_cause} = '0;
    {fuse_current_pin, gauging_enabled_flag, slow} = 3'b000;
    meas = {16'd0, 1'b1, 16'd4000, 16'd3000, 16'd12000, 32'h0};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_defaults;
    t_flags;
    t_latch;
    t_life;
    t_persist;
    test_done;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    test_done;
  end
endmodule : fail_log_test

// >>> verification/nv_store_model.sv
// nonvolatile store model answering the lifetime store handshake
// assumes req holds until ack; slow stretches the answer
`timescale 1ns/1ps
module nv_store_model
  import fail_log_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // store port
  input wire logic nv_store_req,
  input wire lifetime_s nv_store_data,
  output logic nv_store_ack,
  // control and record
  input wire logic slow,
  output lifetime_s stored
);
  logic [3:0] wait_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_store_ack <= 1'b0;
      wait_cnt <= 4'h0;
      stored <= '0;
    end else begin
      nv_store_ack <= 1'b0;
      if (nv_store_req && !nv_store_ack) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt >= (slow ? 4'h6 : 4'h0)) begin
          nv_store_ack <= 1'b1;
          wait_cnt <= 4'h0;
          stored <= nv_store_data;
        end
      end
    end
  end
endmodule : nv_store_model

// >>> verilog/fail_log.sv
// permanent fail latch with shutdown outputs and lifetime extreme log
// assumes fault pulses, measurements and gauging flag come from logic on
// pclk; fuse current sense is an asynchronous pin
//
// How it works
// - low flag byte bits 0..7 latch the eight documented low failure causes
// - high byte latches link, overcurrent, thermistor causes plus fuse blow failure
// - high byte order: link, periodic link, chg oc, dsg oc, thermistor, -, -, fuse
// - 16-bit enable word aligned to flags; high byte bits 4..7 unused
// - flag and enable both set latches shutdown_n low, shutdown high until reset
// - fuse blow failure flag never feeds the shutdown outputs
// - max/min temperature updated after over 60 s beyond, or over 1.0 C step
// - max/min cell voltage updated after over 60 s beyond, or over 25 mV
// - max/min pack voltage updated after over 60 s beyond, or over 100 mV
// - max chg/dsg current from positive/negative average current, 60 s or 100 mA
// - max chg/dsg power updated after over 60 s above, or over 1000 mW
// - simple average of valid temps; stored when it moves over 1 C
// - any trigger stores the complete lifetime set to nonvolatile storage
// - no lifetime update before the gauging enabled flag is set
// - minima reset high: temp 1400, cell 10000 mV, pack 20000 mV; others zero
// - 4-byte sample count, saturates at 140000000, reset zero
`timescale 1ns/1ps
module fail_log
  import fail_log_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fault causes as one-cycle pulses, fuse current sense level
  input wire logic [15:0] fail_cause,
  input wire logic fuse_current_pin,
  // measurements and gauging state
  input wire meas_s meas,
  input wire logic meas_valid,
  input wire logic gauging_enabled_flag,
  // nonvolatile store port
  output logic nv_store_req,
  output lifetime_s nv_store_data,
  input wire logic nv_store_ack,
  // shutdown and interrupt
  output logic shutdown_n,
  output logic shutdown,
  output logic irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  fail_flags_s flags, next_flags;
  logic [15:0] enable, next_enable;
  logic [IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic next_shutdown;
  logic fuse_s1, fuse_s2;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  meas_s meas_q, next_meas_q;
  logic [15:0] lt_val [LT_N];
  logic [LT_N-1:0] trig;
  logic signed [15:0] lt_avg, next_lt_avg;
  logic [31:0] samples, next_samples;
  logic signed [47:0] temp_sum, next_temp_sum;
  logic signed [15:0] avg_now;
  logic avg_trig;
  logic any_trig;
  logic pending, next_pending;
  logic next_nv_store_req;
  lifetime_s next_nv_store_data;
  lifetime_s live;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  logic rd_cycle, wr_cycle;
  logic [31:0] rd_word;
  logic rd_hit;

  // ****************************************************************
  // fuse pin synchroniser
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_s1 <= 1'b0;
      fuse_s2 <= 1'b0;
    end else begin
      fuse_s1 <= fuse_current_pin;
      fuse_s2 <= fuse_s1;
    end
  end

  // ****************************************************************
  // one second tick and measurement latch
  // ****************************************************************
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 32'd1;
    if (tick_cnt >= 32'(TICK_LEN - 1)) begin
      next_tick_cnt = '0;
      next_tick = 1'b1;
    end
    next_meas_q = meas_valid ? meas : meas_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
      meas_q <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      meas_q <= next_meas_q;
    end
  end

  // ****************************************************************
  // extreme trackers
  // ****************************************************************
  for (genvar i = 0; i < LT_N; i++) begin : g_track
    logic signed [17:0] cand, stored, diff;
    logic elig, exceed, big;
    logic [6:0] persist, next_persist;
    logic [15:0] next_val;

    always_comb begin
      cand = '0;
      elig = 1'b1;
      stored = 18'(signed'({1'b0, lt_val[i]}));
      case (i)
        0, 1: begin
          cand = 18'(meas_q.temp);
          stored = 18'(signed'(lt_val[i]));
        end
        2: cand = 18'({2'b00, meas_q.cell_hi});
        3: cand = 18'({2'b00, meas_q.cell_lo});
        4, 5: cand = 18'({2'b00, meas_q.pack});
        6: begin
          cand = 18'(meas_q.avg_cur);
          elig = meas_q.avg_cur > 16'sd0;
        end
        7: begin
          cand = -18'(meas_q.avg_cur);
          elig = meas_q.avg_cur < 16'sd0;
        end
        8: begin
          cand = 18'(meas_q.avg_pwr);
          elig = meas_q.avg_pwr > 16'sd0;
        end
        default: begin
          cand = -18'(meas_q.avg_pwr);
          elig = meas_q.avg_pwr < 16'sd0;
        end
      endcase
      diff = LT_IS_MIN[i] ? stored - cand : cand - stored;
      exceed = elig && (diff > 18'sd0);
      big = diff > 18'(signed'({2'b00, LT_STEP[i]}));
      next_persist = persist;
      if (!exceed) begin
        next_persist = '0;
      end else if (tick && persist <= 7'(PERSIST_S)) begin
        next_persist = persist + 7'd1;
      end
      trig[i] = gauging_enabled_flag && exceed &&
        (big || persist > 7'(PERSIST_S));
      next_val = trig[i] ? cand[15:0] : lt_val[i];
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        persist <= '0;
        lt_val[i] <= LT_RESET[i];
      end else begin
        persist <= trig[i] ? 7'd0 : next_persist;
        lt_val[i] <= next_val;
      end
    end
  end

  // ****************************************************************
  // lifetime average temperature
  // ****************************************************************
  always_comb begin
    next_temp_sum = temp_sum;
    next_samples = samples;
    avg_now = (samples == '0) ? lt_avg :
      16'(temp_sum / signed'({16'h0000, samples}));
    if (meas_valid && meas.temp_ok && gauging_enabled_flag &&
        samples < SAMPLE_LIMIT) begin
      next_temp_sum = temp_sum + 48'(meas.temp);
      next_samples = samples + 32'd1;
    end
    avg_trig = gauging_enabled_flag && (samples != '0) &&
      ((avg_now - lt_avg > 16'(AVG_STEP)) ||
       (lt_avg - avg_now > 16'(AVG_STEP)));
    next_lt_avg = avg_trig ? avg_now : lt_avg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_sum <= '0;
      samples <= '0;
      lt_avg <= '0;
    end else begin
      temp_sum <= next_temp_sum;
      samples <= next_samples;
      lt_avg <= next_lt_avg;
    end
  end

  // ****************************************************************
  // nonvolatile store of the full set
  // ****************************************************************
  always_comb begin
    for (int k = 0; k < LT_N; k++) begin
      live.ext[k] = trig[k] ? next_lt_snapshot(k) : lt_val[k];
    end
    live.avg_temp = next_lt_avg;
    live.samples = samples;
    any_trig = (|trig) || avg_trig;
    next_nv_store_req = nv_store_req;
    next_nv_store_data = nv_store_data;
    next_pending = pending;
    if (nv_store_req && nv_store_ack) begin
      next_nv_store_req = 1'b0;
    end
    if (any_trig) begin
      next_pending = 1'b1;
    end
    if (!next_nv_store_req && next_pending) begin
      next_nv_store_req = 1'b1;
      next_nv_store_data = live;
      next_pending = 1'b0;
    end
  end

  function automatic logic [15:0] next_lt_snapshot(input int k);
    case (k)
      0, 1: next_lt_snapshot = meas_q.temp;
      2: next_lt_snapshot = meas_q.cell_hi;
      3: next_lt_snapshot = meas_q.cell_lo;
      4, 5: next_lt_snapshot = meas_q.pack;
      6: next_lt_snapshot = meas_q.avg_cur;
      7: next_lt_snapshot = -meas_q.avg_cur;
      8: next_lt_snapshot = meas_q.avg_pwr;
      default: next_lt_snapshot = -meas_q.avg_pwr;
    endcase
  endfunction : next_lt_snapshot

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_store_req <= 1'b0;
      nv_store_data <= '0;
      pending <= 1'b0;
    end else begin
      nv_store_req <= next_nv_store_req;
      nv_store_data <= next_nv_store_data;
      pending <= next_pending;
    end
  end

  // ****************************************************************
  // fail flags, shutdown latch, apb registers
  // ****************************************************************
  assign rd_cycle = psel && penable && !pready && !pwrite;
  assign wr_cycle = psel && penable && !pready && pwrite;

  always_comb begin
    rd_hit = 1'b1;
    rd_word = '0;
    case (paddr)
      OFS_FLAGS: rd_word = {16'h0000, flags};
      OFS_ENABLE: rd_word = {16'h0000, enable};
      OFS_IRQ_STAT: rd_word = 32'(irq_stat);
      OFS_IRQ_MASK: rd_word = 32'(irq_mask);
      OFS_STATE: rd_word = {29'h0, nv_store_req, gauging_enabled_flag,
        shutdown};
      OFS_LT_AVG: rd_word = 32'(lt_avg);
      OFS_LT_SAMPLES: rd_word = samples;
      default: begin
        if (paddr >= OFS_LT_BASE && paddr < OFS_LT_AVG &&
            paddr[1:0] == 2'b00) begin
          rd_word = {16'h0000, lt_val[4'((paddr - OFS_LT_BASE) >> 2)]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  always_comb begin
    next_flags = flags | fail_cause;
    next_flags.unused5 = 1'b0;
    next_flags.unused6 = 1'b0;
    if (shutdown && fuse_s2 && tick) begin
      next_flags.fuse_blow_failure = 1'b1;
    end
    next_enable = enable;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (rd_cycle && paddr == OFS_IRQ_STAT) begin
      next_irq_stat = '0;
    end
    if (wr_cycle && paddr == OFS_ENABLE) begin
      next_enable = pwdata[15:0] & ENABLE_WMASK;
    end
    if (wr_cycle && paddr == OFS_IRQ_MASK) begin
      next_irq_mask = pwdata[IRQ_W-1:0];
    end
    next_shutdown = shutdown ||
      (|(16'(next_flags) & enable & SHUTDOWN_MASK));
    if (16'(next_flags) != 16'(flags)) begin
      next_irq_stat[IRQ_NEW_FLAG] = 1'b1;
    end
    if (next_shutdown && !shutdown) begin
      next_irq_stat[IRQ_SHUTDOWN] = 1'b1;
    end
    if (any_trig) begin
      next_irq_stat[IRQ_STORE] = 1'b1;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
    next_pready = psel && penable && !pready;
    next_prdata = rd_cycle ? rd_word : '0;
    next_pslverr = next_pready && !rd_hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
      enable <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
      shutdown <= 1'b0;
      shutdown_n <= 1'b1;
      irq <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      flags <= next_flags;
      enable <= next_enable;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      shutdown <= next_shutdown;
      shutdown_n <= !next_shutdown;
      irq <= next_irq;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule : fail_log
